// *** pkmi_top.sv ***
// Purpose: power-key and misc interrupt status, mask and sense registers
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes:   irq pin is open drain, pulled low while any unmasked status is set
`timescale 1ns/1ps
`default_nettype none
module pkmi_top
  import pkmi_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // pins
  input  wire logic        power_key_n,
  input  wire logic        power_button_input,
  input  wire logic        low_supply_threshold,
  input  wire logic        overvolt_threshold,
  // power sequencer, same clock
  input  wire logic        powerup_in_progress,
  input  wire logic        powerdown_in_progress,
  // interrupt pin
  output var  logic        irq_n_pin_o,
  output var  logic        irq_n_pin_oe
);

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  logic [3:0]  pin_sync;
  logic        key_press_sense;
  logic [4:0]  hold_sense;
  pkmi_misc_t  misc_now;
  // debounce choice lives with the registers but feeds the key timer below
  logic [1:0]  deb_q, deb_d;

  pkmi_sync #(
    .W (4)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({~power_key_n, power_button_input, low_supply_threshold, overvolt_threshold}),
    .sync_out (pin_sync)
  );

  pkmi_key_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_key (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .key_low         (pin_sync[3]),
    .deb_sel         (deb_q),
    .key_press_sense (key_press_sense),
    .hold_sense      (hold_sense)
  );

  always_comb begin
    misc_now.pup_busy   = powerup_in_progress;
    misc_now.pdn_busy   = powerdown_in_progress;
    misc_now.button     = pin_sync[2];
    misc_now.low_supply = pin_sync[1];
    misc_now.overvolt   = pin_sync[0];
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  pkmi_aphase_t ap_q, ap_d;
  logic [31:0]  hrdata_d;
  logic         addr_ok;
  logic         rd_now;
  logic         wr_now;
  logic [7:0]   rd_byte;

  // registers of the event group, declared here for the read mux
  logic [5:0]  key_st_q, key_st_d;
  logic [5:0]  key_mk_q, key_mk_d;
  logic [4:0]  misc_st_q, misc_st_d;
  logic [4:0]  misc_mk_q, misc_mk_d;
  logic        key_prev_q;
  logic [4:0]  hold_prev_q;
  pkmi_misc_t  misc_prev_q;
  logic        irq_q, irq_d;

  always_comb begin
    addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    ap_d.valid = hsel && hready && (htrans == HTRANS_NONSEQ);
    ap_d.write = hwrite;
    ap_d.widx  = addr_ok ? haddr[9:2] : 8'hff;
    rd_now  = ap_d.valid && !hwrite;
    wr_now  = ap_q.valid && ap_q.write;
    case (ap_d.widx)
      IDX_KEY_ST:     rd_byte = {2'h0, key_st_q};
      IDX_KEY_MK:     rd_byte = {2'h0, key_mk_q};
      IDX_KEY_SENSE:  rd_byte = {2'h0, hold_sense, key_press_sense};
      IDX_MISC_ST:    rd_byte = {3'h0, misc_st_q};
      IDX_MISC_MK:    rd_byte = {3'h0, misc_mk_q};
      IDX_MISC_SENSE: rd_byte = {3'h0, misc_now};
      IDX_DEB_CFG:    rd_byte = {6'h0, deb_q};
      default:        rd_byte = 8'h00;
    endcase
    hrdata_d = rd_now ? {24'h0, rd_byte} : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q      <= '0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_q      <= ap_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status, mask and interrupt pin
  // ----------------------------------------------------------------
  logic [5:0] key_set, key_clr;
  logic [4:0] misc_set, misc_clr;

  always_comb begin
    key_set[KEY_PUSH_BIT] = key_press_sense != key_prev_q;
    key_set[5:KEY_HOLD_LSB] = hold_sense & ~hold_prev_q;
    misc_set[MISC_PUP_BIT]  = misc_prev_q.pup_busy && !misc_now.pup_busy;
    misc_set[MISC_PDN_BIT]  = misc_prev_q.pdn_busy && !misc_now.pdn_busy;
    misc_set[MISC_BTN_BIT]  = misc_prev_q.button != misc_now.button;
    misc_set[MISC_LOW_BIT]  = !misc_prev_q.low_supply && misc_now.low_supply;
    misc_set[MISC_OVLO_BIT] = !misc_prev_q.overvolt && misc_now.overvolt;
    // read clears what it returned, a later write of one clears too
    key_clr  = 6'h0;
    misc_clr = 5'h0;
    if (rd_now && ap_d.widx == IDX_KEY_ST) begin
      key_clr = key_st_q;
    end
    if (rd_now && ap_d.widx == IDX_MISC_ST) begin
      misc_clr = misc_st_q;
    end
    if (wr_now && ap_q.widx == IDX_KEY_ST) begin
      key_clr = key_clr | hwdata[5:0];
    end
    if (wr_now && ap_q.widx == IDX_MISC_ST) begin
      misc_clr = misc_clr | hwdata[4:0];
    end
    // a new event in the clearing cycle is kept
    key_st_d  = (key_st_q & ~key_clr) | key_set;
    misc_st_d = (misc_st_q & ~misc_clr) | misc_set;
    key_mk_d  = key_mk_q;
    misc_mk_d = misc_mk_q;
    deb_d     = deb_q;
    if (wr_now && ap_q.widx == IDX_KEY_MK) begin
      key_mk_d = hwdata[5:0];
    end
    if (wr_now && ap_q.widx == IDX_MISC_MK) begin
      misc_mk_d = hwdata[4:0];
    end
    if (wr_now && ap_q.widx == IDX_DEB_CFG) begin
      deb_d = hwdata[1:0];
    end
    irq_d = |(key_st_q & ~key_mk_q) || |(misc_st_q & ~misc_mk_q);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_st_q    <= KEY_ST_RST;
      key_mk_q    <= KEY_MK_RST;
      misc_st_q   <= MISC_ST_RST;
      misc_mk_q   <= MISC_MK_RST;
      deb_q       <= DEB_CFG_RST;
      key_prev_q  <= 1'b0;
      hold_prev_q <= 5'h0;
      misc_prev_q <= '0;
      irq_q       <= 1'b0;
      irq_n_pin_o <= 1'b0;
    end else begin
      key_st_q    <= key_st_d;
      key_mk_q    <= key_mk_d;
      misc_st_q   <= misc_st_d;
      misc_mk_q   <= misc_mk_d;
      deb_q       <= deb_d;
      key_prev_q  <= key_press_sense;
      hold_prev_q <= hold_sense;
      misc_prev_q <= misc_now;
      irq_q       <= irq_d;
      irq_n_pin_o <= 1'b0;
    end
  end

  // open drain: the data flop stays low, only the enable moves the pin
  assign irq_n_pin_oe = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_key_sense_hold: assert property (|hold_sense |-> key_press_sense)
    else $error("hold sense set without key press");
  a_hold_order: assert property (hold_sense[4] |-> &hold_sense[3:0])
    else $error("8 s hold without shorter holds");
  a_hold_release: assert property ($fell(key_press_sense) |-> hold_sense == 5'h0)
    else $error("hold sense survives release");
  a_pup_done: assert property ($fell(powerup_in_progress) |=> misc_st_q[MISC_PUP_BIT])
    else $error("power-up done not flagged");
  a_pdn_done: assert property ($fell(powerdown_in_progress) |=> misc_st_q[MISC_PDN_BIT])
    else $error("power-down done not flagged");
  a_button_evt: assert property ($changed(pin_sync[2]) |=> misc_st_q[MISC_BTN_BIT])
    else $error("button event not flagged");
  a_low_evt: assert property ($rose(pin_sync[1]) |=> misc_st_q[MISC_LOW_BIT])
    else $error("low supply crossing not flagged");
  a_ovlo_evt: assert property ($rose(pin_sync[0]) |=> misc_st_q[MISC_OVLO_BIT])
    else $error("overvoltage crossing not flagged");
  a_w1c_clear: assert property (wr_now && ap_q.widx == IDX_MISC_ST && hwdata[0]
                                && !misc_set[0] |=> !misc_st_q[0])
    else $error("write one did not clear status");
  a_read_clear: assert property (rd_now && ap_d.widx == IDX_MISC_ST && misc_set == 5'h0
                                 |=> misc_st_q == 5'h0 ##0 hrdata[4:0] == $past(misc_st_q))
    else $error("read did not return and clear status");
  a_mask_gate: assert property (misc_mk_q == 5'h1f && key_mk_q == 6'h3f ##1 misc_mk_q == 5'h1f
                                && key_mk_q == 6'h3f |-> !irq_n_pin_oe)
    else $error("masked status drives pin");
  a_mask_reset: assert property ($rose(hresetn) |-> misc_mk_q == 5'h1f)
    else $error("mask not set by reset");
  a_key_push: assert property ($changed(key_press_sense) |=> key_st_q[KEY_PUSH_BIT])
    else $error("key push status not set");
  a_hold_status: assert property ($rose(hold_sense[0]) |=> key_st_q[1])
    else $error("hold status not set");
  a_irq_pin: assert property ((misc_st_q & ~misc_mk_q) != 5'h0 |=> irq_n_pin_oe)
    else $error("unmasked status does not pull pin");

  a_sense_read: assert property (rd_now && ap_d.widx == IDX_MISC_SENSE
                                 |=> hrdata[4:0] == $past(misc_now))
    else $error("misc sense read is not the live level");
  a_key_sense_read: assert property (rd_now && ap_d.widx == IDX_KEY_SENSE
                                     |=> hrdata[0] == $past(key_press_sense)
                                     && hrdata[5:1] == $past(hold_sense))
    else $error("key sense read is not the live level");
  a_unmapped_read: assert property (rd_now && !addr_ok |=> hrdata == 32'h0)
    else $error("unmapped read returned data");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("unused read lanes not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or did not answer okay");
  a_mask_write: assert property (wr_now && ap_q.widx == IDX_MISC_MK
                                 |=> misc_mk_q == $past(hwdata[4:0]))
    else $error("mask write did not land");
  a_deb_write: assert property (wr_now && ap_q.widx == IDX_DEB_CFG
                                |=> deb_q == $past(hwdata[1:0]))
    else $error("debounce choice write did not land");
  a_key_irq: assert property ((key_st_q & ~key_mk_q) != 6'h0 |=> irq_n_pin_oe)
    else $error("unmasked key status does not pull pin");
  a_irq_release: assert property ((key_st_q & ~key_mk_q) == 6'h0
                                  && (misc_st_q & ~misc_mk_q) == 5'h0 |=> !irq_n_pin_oe)
    else $error("pin held with no unmasked status");
  a_status_sticky: assert property (misc_st_q != 5'h0 && !(rd_now && ap_d.widx == IDX_MISC_ST)
                                    && !(wr_now && ap_q.widx == IDX_MISC_ST)
                                    |=> (misc_st_q & $past(misc_st_q)) == $past(misc_st_q))
    else $error("status bit dropped without a clear");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_irq_low: cover property ($rose(irq_n_pin_oe));
  c_read_clear: cover property (rd_now && ap_d.widx == IDX_MISC_ST && misc_st_q != 5'h0);
  c_hold8: cover property ($rose(hold_sense[4]));
  c_set_in_clear: cover property (|(misc_set & misc_clr));
  c_slow_debounce: cover property (deb_q == 2'h1 && $rose(key_press_sense));

endmodule
`default_nettype wire

// *** pkmi_pkg.sv ***
// Purpose: shared constants and types of the power-key and misc interrupt block
// Assumes: 40 MHz hclk, registers reached as aligned words over AHB-Lite
// Notes:   register indices are word numbers, byte address is four times the index
package pkmi_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 40_000_000;
  localparam int MS_PER_S   = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  localparam logic [13:0] HOLD1_MS = 14'd1000;
  localparam logic [13:0] HOLD2_MS = 14'd2000;
  localparam logic [13:0] HOLD3_MS = 14'd3000;
  localparam logic [13:0] HOLD4_MS = 14'd4000;
  localparam logic [13:0] HOLD8_MS = 14'd8000;

  localparam logic [6:0] DEB0_MS = 7'd1;
  localparam logic [6:0] DEB1_MS = 7'd16;
  localparam logic [6:0] DEB2_MS = 7'd32;
  localparam logic [6:0] DEB3_MS = 7'd64;

  // ----------------------------------------------------------------
  // register indices and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_KEY_ST     = 8'h24;
  localparam logic [7:0] IDX_KEY_MK     = 8'h25;
  localparam logic [7:0] IDX_KEY_SENSE  = 8'h26;
  localparam logic [7:0] IDX_MISC_ST    = 8'h28;
  localparam logic [7:0] IDX_MISC_MK    = 8'h29;
  localparam logic [7:0] IDX_MISC_SENSE = 8'h2a;
  localparam logic [7:0] IDX_DEB_CFG    = 8'h2f;

  localparam logic [5:0] KEY_ST_RST  = 6'h00;
  localparam logic [5:0] KEY_MK_RST  = 6'h3f;
  localparam logic [4:0] MISC_ST_RST = 5'h00;
  localparam logic [4:0] MISC_MK_RST = 5'h1f;
  localparam logic [1:0] DEB_CFG_RST = 2'h0;

  // field positions
  localparam int KEY_PUSH_BIT  = 0;
  localparam int KEY_HOLD_LSB  = 1;
  localparam int MISC_PUP_BIT  = 0;
  localparam int MISC_PDN_BIT  = 1;
  localparam int MISC_BTN_BIT  = 2;
  localparam int MISC_LOW_BIT  = 3;
  localparam int MISC_OVLO_BIT = 4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic overvolt;
    logic low_supply;
    logic button;
    logic pdn_busy;
    logic pup_busy;
  } pkmi_misc_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] widx;
  } pkmi_aphase_t;

  function automatic logic [6:0] pkmi_deb_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    pkmi_deb_ms = DEB0_MS;
      2'h1:    pkmi_deb_ms = DEB1_MS;
      2'h2:    pkmi_deb_ms = DEB2_MS;
      default: pkmi_deb_ms = DEB3_MS;
    endcase
  endfunction

endpackage

// *** pkmi_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels, no bus coherency needed between bits
// Notes:   reset value is zero for every bit
`timescale 1ns/1ps
`default_nettype none
module pkmi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// *** pkmi_key_timer.sv ***
// Purpose: power-key debounce and hold-duration timing
// Assumes: key_low is synchronised, 1 while the key is pressed
// Notes:   timing rests on a free-running 1 ms tick, so each time is +0/-1 ms
`timescale 1ns/1ps
`default_nettype none
module pkmi_key_timer
  import pkmi_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // key level and debounce choice
  input  wire logic       key_low,
  input  wire logic [1:0] deb_sel,
  // debounced state
  output var  logic       key_press_sense,
  output var  logic [4:0] hold_sense
);

  typedef enum logic [1:0] {
    PKMI_REL, PKMI_PRESS_WAIT, PKMI_PRESSED, PKMI_REL_WAIT
  } pkmi_key_t;

  pkmi_key_t   st_q, st_d;
  logic [31:0] ms_q, ms_d;
  logic [6:0]  dcnt_q, dcnt_d;
  logic [13:0] hcnt_q, hcnt_d;
  logic        tick;
  logic [6:0]  deb;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    tick   = (ms_q == 32'(MS_CYCLES - 1));
    ms_d   = tick ? 32'h0 : ms_q + 32'h1;
    deb    = pkmi_deb_ms(deb_sel);
    st_d   = st_q;
    dcnt_d = dcnt_q;
    case (st_q)
      PKMI_REL: begin
        dcnt_d = 7'h0;
        if (key_low) begin
          st_d = PKMI_PRESS_WAIT;
        end
      end
      PKMI_PRESS_WAIT: begin
        if (!key_low) begin
          st_d = PKMI_REL;
        end else if (tick) begin
          dcnt_d = dcnt_q + 7'h1;
          if (dcnt_q + 7'h1 >= deb) begin
            st_d   = PKMI_PRESSED;
            dcnt_d = 7'h0;
          end
        end
      end
      PKMI_PRESSED: begin
        dcnt_d = 7'h0;
        if (!key_low) begin
          st_d = PKMI_REL_WAIT;
        end
      end
      PKMI_REL_WAIT: begin
        if (key_low) begin
          st_d   = PKMI_PRESSED;
          dcnt_d = 7'h0;
        end else if (tick) begin
          dcnt_d = dcnt_q + 7'h1;
          if (dcnt_q + 7'h1 >= deb) begin
            st_d = PKMI_REL;
          end
        end
      end
      default: begin
        st_d = PKMI_REL;
      end
    endcase
    // hold time restarts only when the debounced level shows release
    if (st_d == PKMI_REL || st_d == PKMI_PRESS_WAIT) begin
      hcnt_d = 14'h0;
    end else if (tick && hcnt_q < HOLD8_MS) begin
      hcnt_d = hcnt_q + 14'h1;
    end else begin
      hcnt_d = hcnt_q;
    end
    key_press_sense = (st_q == PKMI_PRESSED) || (st_q == PKMI_REL_WAIT);
    hold_sense[0] = key_press_sense && hcnt_q >= HOLD1_MS;
    hold_sense[1] = key_press_sense && hcnt_q >= HOLD2_MS;
    hold_sense[2] = key_press_sense && hcnt_q >= HOLD3_MS;
    hold_sense[3] = key_press_sense && hcnt_q >= HOLD4_MS;
    hold_sense[4] = key_press_sense && hcnt_q >= HOLD8_MS;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q   <= PKMI_REL;
      ms_q   <= 32'h0;
      dcnt_q <= 7'h0;
      hcnt_q <= 14'h0;
    end else begin
      st_q   <= st_d;
      ms_q   <= ms_d;
      dcnt_q <= dcnt_d;
      hcnt_q <= hcnt_d;
    end
  end

endmodule
`default_nettype wire

// *** pkmi_host.sv ***
// Purpose: host processor model, ahb-lite master and pulled-up irq pin
// Assumes: one slave, single word transfers, okay only
// Notes:   waits on hready with no cycle count, the bench timeout ends a hang
`timescale 1ns/1ps
`default_nettype none
module pkmi_host
  import pkmi_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // ahb-lite master
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // interrupt pin
  input  wire logic        irq_n_pin_o,
  input  wire logic        irq_n_pin_oe,
  output wire logic        irq_level
);
  // ----------------------------------------------------------------
  // pin and bus
  // ----------------------------------------------------------------
  // open drain, the board pull-up wins whenever the device lets go
  assign irq_level = irq_n_pin_oe ? irq_n_pin_o : 1'b1;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // a read of a status register is also its acknowledge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // stale write data must not look valid after the data phase
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

// *** power_key_misc_interrupt_regs_tb_top.sv ***
// Purpose: self-checking bench for the power-key and misc interrupt block
// Assumes: one ms is MSC cycles, slow debounce tried once near the end
// Notes:   status model is a 5-bit mask, read and write-one both clear
`timescale 1ns/1ps
`default_nettype none
module power_key_misc_interrupt_regs_tb_top;
  import pkmi_pkg::*;
  localparam int MSC = 4;
  localparam int SEC = 1000 * MSC;

  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        key_n;
  logic [4:0]  misc;
  logic        irq_o;
  logic        irq_oe;
  logic        irq_level;
  logic [4:0]  exp_st;
  logic [4:0]  mk;
  logic [31:0] rd;
  int          miscompares = 0;
  int          total_checks = 0;

  always #12.5 hclk = ~hclk;

  pkmi_top #(.MS_CYCLES(MSC)) i_pkmi_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .power_key_n(key_n), .power_button_input(misc[2]),
    .low_supply_threshold(misc[3]), .overvolt_threshold(misc[4]),
    .powerup_in_progress(misc[0]), .powerdown_in_progress(misc[1]),
    .irq_n_pin_o(irq_o), .irq_n_pin_oe(irq_oe)
  );

  pkmi_host i_pkmi_host (
    .hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata,
    .irq_n_pin_o(irq_o), .irq_n_pin_oe(irq_oe), .irq_level
  );

  // ----------------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_pin(input logic exp);
    total_checks++;
    if (irq_level !== exp) begin
      miscompares++;
      $display("BAD irq_pin expected %b seen %b", exp, irq_level);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [7:0] exp);
    i_pkmi_host.xfer(1'b0, a, 32'h0, rd);
    chk_reg(nm, {24'h0, exp}, rd);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_pkmi_host.xfer(1'b1, a, d, rd);
  endtask

  // events: transitions end on a fall, button on any change, supply on a rise
  task automatic set_misc(input logic [4:0] v);
    exp_st = exp_st | (misc & ~v & 5'h03) | ((misc ^ v) & 5'h04) | (~misc & v & 5'h18);
    misc <= v;
    repeat (6) @(posedge hclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    key_n   = 1'b1;
    misc    = 5'h0;
    exp_st  = 5'h0;
    void'($urandom(18));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("misc_mask", 32'ha4, 8'h1f);
    rd_chk("misc_status", 32'ha0, 8'h00);
    rd_chk("unmapped", 32'h0, 8'h00);
    chk_reg("hresp", 32'h0, {31'h0, hresp});
    chk_pin(1'b1);
    for (int i = 0; i < 5; i++) begin
      set_misc(5'h01 << i);
      rd_chk("misc_sense", 32'ha8, {3'h0, misc});
      set_misc(5'h00);
      rd_chk("misc_status", 32'ha0, {3'h0, exp_st});
      exp_st = 5'h0;
      rd_chk("misc_status", 32'ha0, 8'h00);
    end
    for (int n = 0; n < 16; n++) begin
      mk = 5'($urandom());
      wr(32'ha4, {27'h0, mk});
      rd_chk("misc_mask", 32'ha4, {3'h0, mk});
      set_misc(5'($urandom()));
      rd_chk("misc_sense", 32'ha8, {3'h0, misc});
      chk_pin(~|(exp_st & ~mk));
      rd_chk("misc_status", 32'ha0, {3'h0, exp_st});
      exp_st = 5'h0;
      repeat (2) @(posedge hclk);
      chk_pin(1'b1);
    end
    set_misc(5'h00);
    rd_chk("misc_status", 32'ha0, {3'h0, exp_st});
    exp_st = 5'h0;
    wr(32'ha4, 32'h0);
    set_misc(5'h04);
    chk_pin(1'b0);
    wr(32'ha0, 32'h1b);
    repeat (2) @(posedge hclk);
    chk_pin(1'b0);
    wr(32'ha0, 32'h04);
    exp_st = 5'h0;
    repeat (2) @(posedge hclk);
    chk_pin(1'b1);
    // a falling button level is an event too, then a reset in mid-run must mask again
    set_misc(5'h00);
    chk_pin(1'b0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    exp_st = 5'h0;
    chk_pin(1'b1);
    rd_chk("misc_mask", 32'ha4, 8'h1f);
    rd_chk("misc_status", 32'ha0, 8'h00);
    // key press, hold past every duration, then release
    key_n <= 1'b0;
    repeat (40) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h01);
    repeat (SEC + 20) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h03);
    rd_chk("key_status", 32'h90, 8'h03);
    chk_pin(1'b1);
    repeat (7 * SEC + 100) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h3f);
    rd_chk("key_status", 32'h90, 8'h3c);
    key_n <= 1'b1;
    repeat (40) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h00);
    rd_chk("key_status", 32'h90, 8'h01);
    // slow debounce: 16 ms is 64 cycles here, so a read after 40 still sees release
    wr(32'hbc, 32'h3);
    rd_chk("deb_cfg", 32'hbc, 8'h03);
    wr(32'hbc, 32'h1);
    rd_chk("deb_cfg", 32'hbc, 8'h01);
    wr(32'h94, 32'h3e);
    rd_chk("key_mask", 32'h94, 8'h3e);
    key_n <= 1'b0;
    repeat (40) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h00);
    chk_pin(1'b1);
    repeat (40) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h01);
    chk_pin(1'b0);
    wr(32'h90, 32'h01);
    repeat (2) @(posedge hclk);
    chk_pin(1'b1);
    rd_chk("key_status", 32'h90, 8'h00);
    key_n <= 1'b1;
    repeat (100) @(posedge hclk);
    rd_chk("key_sense", 32'h98, 8'h00);
    rd_chk("key_status", 32'h90, 8'h01);
    end_of_test();
  end

  initial begin
    #(60000 * 25);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
